// >>> common/sphpi_pkg.sv
// Notes on behaviour
// - after a data or extended record checksum, skip bytes until start mark
// - host sends nothing after end checksum, awaits two
// - receive or format error halts, no code
// - record type other than 00/01/02 is error
// - record checksum mismatch is a format error
// - extended record length other than two errors
// - data record after extended address >=1000H errors
// - end record with nonzero length errors
// - password at least eight bytes, compared bytewise
// - password region only inside the flash ranges
// - all FFH at top 32 bytes means blank
// - host always sends both password addresses
// - length and compare addresses must be in range
// - three identical stored bytes is password error
// - blank write mode goes straight to records
// - erase mode, blank device gets no password
// - address or length violation halts silently
// - any password byte mismatch halts silently
// - after halt host waits for device reset
// - identification reply is 21 fixed bytes
// - ROM block addresses sent upper byte first
// - last identification byte is negated sum 44H
// - halt stops all link traffic until reset
package sphpi_pkg;
    localparam logic [7:0] START_MARK = 8'h3a;
    localparam logic [7:0] REC_DATA = 8'h00;
    localparam logic [7:0] REC_END = 8'h01;
    localparam logic [7:0] REC_EXT = 8'h02;
    localparam logic [7:0] EXT_LEN = 8'h02;
    localparam logic [7:0] END_LEN = 8'h00;
    localparam logic [15:0] EXT_LIMIT = 16'h1000;
    localparam logic [23:0] ROM1_LO = 24'h004000;
    localparam logic [23:0] ROM1_HI = 24'h021eff;
    localparam logic [23:0] PW_COMPARE_START_ADDR_TOP = 24'h021f00;
    localparam logic [19:0] BLANK_LO = 20'hfffe0;
    localparam logic [7:0] BLANK_CNT = 8'h20;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] PW_MIN_LEN = 8'h08;
    localparam logic [7:0] ADDR_BYTES = 8'h06;
    localparam logic [7:0] ID_LEN = 8'h15;
    localparam logic [7:0] SUM_BYTES = 8'h02;
    // first twenty identification bytes, first byte in the top lane
    localparam logic [159:0] ID_TBL = 160'h3a12033d00000002004000021eff0fff000fffff;

    function automatic logic [7:0] id_byte(input logic [4:0] idx);
        logic [7:0] s;
        s = 8'h00;
        for (int k = 2; k < 20; k++) begin
            s = s + ID_TBL[(19 - k) * 8 +: 8];
        end
        if (idx < 5'd20) begin
            id_byte = ID_TBL[(19 - idx) * 8 +: 8];
        end else begin
            id_byte = ~s + 8'h01;
        end
    endfunction

    function automatic logic in_main(input logic [23:0] a);
        in_main = (a >= ROM1_LO) && (a <= ROM1_HI);
    endfunction
endpackage

// >>> common/sphpi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sphpi_link_if;
    logic [7:0] h2d_data;
    logic h2d_valid;
    logic h2d_rx_err;
    logic [7:0] d2h_data;
    logic d2h_valid;
    logic d2h_ready;
    logic dev_halted;

    modport dev (
        input h2d_data, h2d_valid, h2d_rx_err, d2h_ready,
        output d2h_data, d2h_valid, dev_halted
    );
    modport host (
        output h2d_data, h2d_valid, h2d_rx_err, d2h_ready,
        input d2h_data, d2h_valid, dev_halted
    );
endinterface
`default_nettype wire

// >>> rtl/sphpi_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sphpi_dev (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link to the programming controller
    sphpi_link_if.dev link,
    // mode requests
    input wire logic i_id_req,
    input wire logic i_pw_req,
    input wire logic i_pw_hex,
    input wire logic [15:0] i_flash_sum,
    // flash read port: data is sampled at the edge that ends the strobe
    output logic [19:0] o_flash_addr,
    output logic o_flash_rd,
    input wire logic [7:0] i_flash_data,
    // record output
    output logic o_wr_valid,
    output logic [19:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_end_rec,
    // status
    output logic o_pw_ok,
    output logic o_blank,
    output logic o_halt,
    output logic o_pw_err,
    output logic o_fmt_err
);
    import sphpi_pkg::*;

    typedef enum logic [11:0] {
        ST_IDLE = 12'h001, ST_ID = 12'h002, ST_BLANK = 12'h004, ST_PWADR = 12'h008,
        ST_PWLEN = 12'h010, ST_PWCMP = 12'h020, ST_HMARK = 12'h040, ST_HHDR = 12'h080,
        ST_HDATA = 12'h100, ST_HCKS = 12'h200, ST_SUMTX = 12'h400, ST_HALT = 12'h800
    } sphpi_dev_st_t;

    sphpi_dev_st_t state_reg;
    logic pend_reg, blank_reg, hexmode_reg, tx_valid_reg, flash_rd_reg, wr_valid_reg;
    logic end_rec_reg, pw_ok_reg, halt_reg, pw_err_reg, fmt_err_reg;
    logic [7:0] cnt_reg, pwlen_reg, rxb_reg, prev1_reg, prev2_reg, sum_reg, len_reg;
    logic [7:0] typ_reg, tx_data_reg, wr_data_reg;
    logic [15:0] addr_reg, ext_reg, sum_out_reg;
    logic [19:0] flash_addr_reg, wr_addr_reg;
    logic [23:0] pw_length_store_addr_reg, pw_compare_start_addr_reg;

    wire rx = link.h2d_valid;
    wire [7:0] rxd = link.h2d_data;
    wire tx_free = !tx_valid_reg || link.d2h_ready;
    wire [23:0] pw_compare_start_addr_full = {pw_compare_start_addr_reg[15:0], rxd};
    wire addr_done = (state_reg == ST_PWADR) && rx && (cnt_reg == ADDR_BYTES - 8'h01);
    wire [24:0] pw_end = {1'b0, pw_compare_start_addr_reg} + {17'h00000, i_flash_data};
    wire pw_compare_start_addr_fit = (pw_compare_start_addr_reg >= ROM1_LO) && (pw_end <= {1'b0, PW_COMPARE_START_ADDR_TOP});
    wire run3 = (cnt_reg >= 8'h02) && (i_flash_data == prev1_reg)
        && (prev1_reg == prev2_reg);
    wire addr_bad = addr_done
        && (!in_main(pw_length_store_addr_reg) || (blank_reg && !in_main(pw_compare_start_addr_full)));
    wire len_bad = (state_reg == ST_PWLEN) && pend_reg
        && ((i_flash_data < PW_MIN_LEN) || !pw_compare_start_addr_fit);
    wire cmp_bad = (state_reg == ST_PWCMP) && pend_reg
        && ((i_flash_data != rxb_reg) || run3);
    wire pw_fail = addr_bad || len_bad || cmp_bad;
    wire typ_bad = (rxd != REC_DATA) && (rxd != REC_END) && (rxd != REC_EXT);
    wire hdr_bad = (state_reg == ST_HHDR) && rx && (cnt_reg == 8'h03)
        && (typ_bad
        || ((rxd == REC_EXT) && (len_reg != EXT_LEN))
        || ((rxd == REC_END) && (len_reg != END_LEN))
        || ((rxd == REC_DATA) && (ext_reg >= EXT_LIMIT)));
    wire cks_bad = (state_reg == ST_HCKS) && rx && ((sum_reg + rxd) != 8'h00);
    wire rx_state = (state_reg == ST_PWADR) || (state_reg == ST_PWCMP)
        || (state_reg == ST_HMARK) || (state_reg == ST_HHDR)
        || (state_reg == ST_HDATA) || (state_reg == ST_HCKS);
    wire rx_fail = link.h2d_rx_err && rx_state;
    wire fmt_fail = hdr_bad || cks_bad || rx_fail;
    wire [19:0] wr_base = {ext_reg, 4'h0} + {4'h0, addr_reg};

    // data path registers are loaded before use, so only control and outputs reset
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            pend_reg <= 1'b0;
            blank_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            flash_addr_reg <= 20'h00000;
            flash_rd_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_addr_reg <= 20'h00000;
            wr_data_reg <= 8'h00;
            end_rec_reg <= 1'b0;
            pw_ok_reg <= 1'b0;
            halt_reg <= 1'b0;
            pw_err_reg <= 1'b0;
            fmt_err_reg <= 1'b0;
        end else begin
            flash_rd_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            end_rec_reg <= 1'b0;
            pw_ok_reg <= 1'b0;
            tx_valid_reg <= tx_valid_reg && !link.d2h_ready;
            if (pw_fail || fmt_fail) begin
                // pending byte dropped too, no error code
                state_reg <= ST_HALT;
                halt_reg <= 1'b1;
                pw_err_reg <= pw_fail;
                fmt_err_reg <= fmt_fail;
                tx_valid_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        cnt_reg <= 8'h00;
                        if (i_id_req) begin
                            state_reg <= ST_ID;
                        end else if (i_pw_req) begin
                            state_reg <= ST_BLANK;
                            blank_reg <= 1'b1;
                            hexmode_reg <= i_pw_hex;
                        end
                    end
                    ST_ID: begin
                        if (tx_free) begin
                            tx_data_reg <= id_byte(cnt_reg[4:0]);
                            tx_valid_reg <= 1'b1;
                            cnt_reg <= cnt_reg + 8'h01;
                            if (cnt_reg == ID_LEN - 8'h01) begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_BLANK: begin
                        if (!pend_reg) begin
                            flash_addr_reg <= BLANK_LO + {12'h000, cnt_reg};
                            flash_rd_reg <= 1'b1;
                            pend_reg <= 1'b1;
                        end else begin
                            pend_reg <= 1'b0;
                            if (i_flash_data != BLANK_BYTE) begin
                                blank_reg <= 1'b0;
                            end
                            cnt_reg <= cnt_reg + 8'h01;
                            if (cnt_reg == BLANK_CNT - 8'h01) begin
                                state_reg <= ST_PWADR;
                                cnt_reg <= 8'h00;
                            end
                        end
                    end
                    ST_PWADR: begin
                        if (rx) begin
                            if (cnt_reg < 8'h03) begin
                                pw_length_store_addr_reg <= {pw_length_store_addr_reg[15:0], rxd};
                            end
                            pw_compare_start_addr_reg <= pw_compare_start_addr_full;
                            cnt_reg <= cnt_reg + 8'h01;
                            if (addr_done) begin
                                cnt_reg <= 8'h00;
                                ext_reg <= 16'h0000;
                                if (blank_reg) begin
                                    // blank: no string, records or erase follow
                                    pw_ok_reg <= 1'b1;
                                    state_reg <= hexmode_reg ? ST_HMARK : ST_IDLE;
                                end else begin
                                    flash_addr_reg <= pw_length_store_addr_reg[19:0];
                                    flash_rd_reg <= 1'b1;
                                    pend_reg <= 1'b1;
                                    state_reg <= ST_PWLEN;
                                end
                            end
                        end
                    end
                    ST_PWLEN: begin
                        pend_reg <= 1'b0;
                        pwlen_reg <= i_flash_data;
                        state_reg <= ST_PWCMP;
                    end
                    ST_PWCMP: begin
                        // one flash read per byte: bytes must come >= 2 cycles apart
                        if (!pend_reg && rx) begin
                            rxb_reg <= rxd;
                            flash_addr_reg <= pw_compare_start_addr_reg[19:0] + {12'h000, cnt_reg};
                            flash_rd_reg <= 1'b1;
                            pend_reg <= 1'b1;
                        end else if (pend_reg) begin
                            pend_reg <= 1'b0;
                            prev1_reg <= i_flash_data;
                            prev2_reg <= prev1_reg;
                            cnt_reg <= cnt_reg + 8'h01;
                            if (cnt_reg == pwlen_reg - 8'h01) begin
                                cnt_reg <= 8'h00;
                                pw_ok_reg <= 1'b1;
                                state_reg <= hexmode_reg ? ST_HMARK : ST_IDLE;
                            end
                        end
                    end
                    ST_HMARK: begin
                        if (rx && (rxd == START_MARK)) begin
                            state_reg <= ST_HHDR;
                            cnt_reg <= 8'h00;
                            sum_reg <= 8'h00;
                        end
                    end
                    ST_HHDR: begin
                        if (rx) begin
                            sum_reg <= sum_reg + rxd;
                            cnt_reg <= cnt_reg + 8'h01;
                            if (cnt_reg == 8'h03) begin
                                typ_reg <= rxd;
                                cnt_reg <= 8'h00;
                                state_reg <= (len_reg == 8'h00) ? ST_HCKS : ST_HDATA;
                            end else begin
                                {len_reg, addr_reg} <= {addr_reg, rxd};
                            end
                        end
                    end
                    ST_HDATA: begin
                        if (rx) begin
                            sum_reg <= sum_reg + rxd;
                            cnt_reg <= cnt_reg + 8'h01;
                            // written before the checksum is known; a bad one halts after
                            wr_valid_reg <= (typ_reg == REC_DATA);
                            wr_addr_reg <= wr_base;
                            wr_data_reg <= rxd;
                            addr_reg <= addr_reg + 16'h0001;
                            if (typ_reg == REC_EXT) begin
                                ext_reg <= {ext_reg[7:0], rxd};
                            end
                            if (cnt_reg == len_reg - 8'h01) begin
                                state_reg <= ST_HCKS;
                            end
                        end
                    end
                    ST_HCKS: begin
                        if (rx) begin
                            cnt_reg <= 8'h00;
                            if (typ_reg == REC_END) begin
                                state_reg <= ST_SUMTX;
                                sum_out_reg <= i_flash_sum;
                                end_rec_reg <= 1'b1;
                            end else begin
                                state_reg <= ST_HMARK;
                            end
                        end
                    end
                    ST_SUMTX: begin
                        if (tx_free) begin
                            tx_data_reg <= (cnt_reg == 8'h00) ? sum_out_reg[15:8] : sum_out_reg[7:0];
                            tx_valid_reg <= 1'b1;
                            cnt_reg <= cnt_reg + 8'h01;
                            if (cnt_reg == SUM_BYTES - 8'h01) begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_HALT: begin // only reset leaves here
                    end
                endcase
            end
        end
    end

    assign link.d2h_data = tx_data_reg;
    assign link.d2h_valid = tx_valid_reg;
    assign link.dev_halted = halt_reg;
    assign o_flash_addr = flash_addr_reg;
    assign o_flash_rd = flash_rd_reg;
    assign o_wr_valid = wr_valid_reg;
    assign o_wr_addr = wr_addr_reg;
    assign o_wr_data = wr_data_reg;
    assign o_end_rec = end_rec_reg;
    assign o_pw_ok = pw_ok_reg;
    assign o_blank = blank_reg;
    assign o_halt = halt_reg;
    assign o_pw_err = pw_err_reg;
    assign o_fmt_err = fmt_err_reg;
endmodule
`default_nettype wire

// >>> rtl/sphpi_host.sv
`timescale 1ns/1ps
`default_nettype none
module sphpi_host #(
    parameter logic [7:0] GAP = 8'h04
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link to the device
    sphpi_link_if.host link,
    // byte stream to send
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_tx_end_cks,
    output logic o_tx_ready,
    // line fault injection toward the device receiver
    input wire logic i_line_err,
    // received bytes and checksum
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic [15:0] o_sum,
    output logic o_sum_valid,
    output logic o_dev_halted
);
    import sphpi_pkg::*;

    typedef enum logic [2:0] {
        HS_RUN = 3'b001,
        HS_WSUM = 3'b010,
        HS_DEAD = 3'b100
    } sphpi_host_st_t;

    sphpi_host_st_t state_reg, state_next;
    logic [7:0] gap_reg, gap_next, h2d_data_reg, rx_data_reg;
    logic ready_reg, h2d_valid_reg, err_reg, rx_valid_reg;
    logic sum_valid_reg, sum_half_reg, halted_reg;
    logic [15:0] sum_reg;

    wire take = ready_reg && i_tx_valid;
    wire got = link.d2h_valid;

    always_comb begin
        state_next = state_reg;
        gap_next = (gap_reg != 8'h00) ? gap_reg - 8'h01 : 8'h00;
        if (take) begin
            gap_next = GAP;
        end
        if (link.dev_halted) begin
            state_next = HS_DEAD;
        end else if (take && i_tx_end_cks) begin
            state_next = HS_WSUM;
        end else if ((state_reg == HS_WSUM) && got && sum_half_reg) begin
            state_next = HS_RUN;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg <= HS_RUN;
            gap_reg <= 8'h00;
            ready_reg <= 1'b0;
            h2d_data_reg <= 8'h00;
            h2d_valid_reg <= 1'b0;
            err_reg <= 1'b0;
            rx_data_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            sum_reg <= 16'h0000;
            sum_valid_reg <= 1'b0;
            sum_half_reg <= 1'b0;
            halted_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            gap_reg <= gap_next;
            // byte order is the user's
            ready_reg <= (state_next == HS_RUN) && (gap_next == 8'h00) && !take;
            h2d_valid_reg <= take;
            err_reg <= i_line_err && (state_reg != HS_DEAD);
            if (take) begin
                h2d_data_reg <= i_tx_data;
            end
            rx_valid_reg <= got;
            sum_valid_reg <= 1'b0;
            if (got) begin
                rx_data_reg <= link.d2h_data;
            end
            if ((state_reg == HS_WSUM) && got) begin
                sum_reg <= {sum_reg[7:0], link.d2h_data};
                sum_half_reg <= !sum_half_reg;
                sum_valid_reg <= sum_half_reg;
            end
            halted_reg <= link.dev_halted;
        end
    end

    assign link.h2d_data = h2d_data_reg;
    assign link.h2d_valid = h2d_valid_reg;
    assign link.h2d_rx_err = err_reg;
    assign link.d2h_ready = 1'b1;
    assign o_tx_ready = ready_reg;
    assign o_rx_data = rx_data_reg;
    assign o_rx_valid = rx_valid_reg;
    assign o_sum = sum_reg;
    assign o_sum_valid = sum_valid_reg;
    assign o_dev_halted = halted_reg;
endmodule
`default_nettype wire

// >>> verification/sphpi_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sphpi_link_sva (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // link signals
    input wire logic [7:0] h2d_data,
    input wire logic h2d_valid,
    input wire logic h2d_rx_err,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_valid,
    input wire logic d2h_ready,
    input wire logic dev_halted
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic prev_reg;
    logic [3:0] quiet_reg;
    wire logic first = d2h_valid && !prev_reg;
    // cycles since the last link input
    always_ff @(posedge i_ref_clk) begin
        prev_reg <= !i_sys_rst && d2h_valid;
        quiet_reg <= (i_sys_rst || h2d_valid || h2d_rx_err) ? 4'h0
            : quiet_reg + {3'h0, quiet_reg != 4'hf};
    end
    chk_halt_sticky: assert property (dev_halted |=> dev_halted)
        else $error("halt flag dropped");
    chk_halt_silent: assert property (dev_halted |-> !d2h_valid)
        else $error("device sent while halted");
    chk_host_stops: assert property (dev_halted && $past(dev_halted, 3) |-> !h2d_valid)
        else $error("host sent after halt");
    chk_halt_cause: assert property ($rose(dev_halted) |-> quiet_reg < 4'h8)
        else $error("halt without link cause");
    chk_id_head: assert property (first && d2h_data == 8'h3a |=>
        d2h_data == 8'h12 ##1 d2h_data == 8'h03 ##5 d2h_data == 8'h02)
        else $error("identification header wrong");
    chk_id_len: assert property (first && d2h_data == 8'h3a |->
        d2h_valid [*8] ##1 d2h_valid [*8] ##1 d2h_valid [*5] ##1 !d2h_valid)
        else $error("identification length wrong");
    chk_id_tail: assert property (d2h_valid && $past(d2h_valid) && $past(d2h_valid, 3) &&
        $past(d2h_data, 3) == 8'h0f && $past(d2h_data, 2) == 8'hff && $past(d2h_data) == 8'hff
        |-> d2h_data == 8'h44)
        else $error("identification checksum wrong");
    chk_sum_pair: assert property (first && d2h_data != 8'h3a |=> d2h_valid ##1 !d2h_valid)
        else $error("checksum reply not two bytes");
    chk_host_waits: assert property (first && d2h_data != 8'h3a |-> !h2d_valid [*3])
        else $error("host sent during checksum reply");
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module testbench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, id_req = 1'b0, pw_req = 1'b0, pw_hex = 1'b0;
    logic line_err = 1'b0, tx_valid = 1'b0, tx_end = 1'b0, pok_seen, end_seen;
    logic [7:0] tx_data = 8'h00, fdat, wdat, rxd;
    logic [15:0] fsum = 16'h0000, sum, ext;
    logic [19:0] faddr, wa;
    logic frd, wv, wend, pok, blank, halt, perr, ferr, tx_ready, rxv, sumv, hh;
    logic [7:0] fmem [logic [19:0]];
    logic [7:0] rxq [$];
    logic [27:0] wrq [$], expq [$];
    int n_mismatch = 0, check_count = 0, cyc = 0, seed = 7;
    sphpi_link_if link ();
    sphpi_dev sphpi_dev_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .link(link), .i_id_req(id_req),
        .i_pw_req(pw_req), .i_pw_hex(pw_hex), .i_flash_sum(fsum), .o_flash_addr(faddr),
        .o_flash_rd(frd), .i_flash_data(fdat), .o_wr_valid(wv), .o_wr_addr(wa), .o_wr_data(wdat),
        .o_end_rec(wend), .o_pw_ok(pok), .o_blank(blank), .o_halt(halt), .o_pw_err(perr),
        .o_fmt_err(ferr));
    sphpi_host #(.GAP(8'h02)) sphpi_host_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .link(link),
        .i_tx_data(tx_data), .i_tx_valid(tx_valid), .i_tx_end_cks(tx_end), .o_tx_ready(tx_ready),
        .i_line_err(line_err), .o_rx_data(rxd), .o_rx_valid(rxv), .o_sum(sum), .o_sum_valid(sumv),
        .o_dev_halted(hh));
    sphpi_link_sva sphpi_link_sva_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
        .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid), .h2d_rx_err(link.h2d_rx_err),
        .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready),
        .dev_halted(link.dev_halted));
    always #25 ref_clk = ~ref_clk;
    // the device samples read data at the edge that ends its strobe
    always @* fdat = fmem.exists(faddr) ? fmem[faddr] : 8'hff;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rxv === 1'b1) rxq.push_back(rxd);
        if (wv === 1'b1) wrq.push_back({wa, wdat});
        if (pok === 1'b1) pok_seen <= 1'b1;
        if (wend === 1'b1) end_seen <= 1'b1;
        if (sumv === 1'b1) `CHK("sum", fsum, sum)
        if (cyc == 30000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        int t;
        t = 0;
        @(posedge ref_clk) {tx_data, tx_valid, tx_end} <= {b, 1'b1, e};
        // a halted host never takes it
        do @(negedge ref_clk); while (tx_ready !== 1'b1 && halt !== 1'b1 && (t++) < 200);
        @(posedge ref_clk) tx_valid <= 1'b0;
    endtask
    task automatic rst_dev;
        @(posedge ref_clk) sys_rst <= 1'b1;
        tick(12);
        rxq.delete();
        wrq.delete();
        expq.delete();
        {pok_seen, end_seen, ext} = 18'h0;
        // top byte never a start mark, so the reply cannot pass for an id reply
        fsum <= 16'($random(seed)) | 16'h8000;
        sys_rst <= 1'b0;
        tick(1);
    endtask
    task automatic start(input logic hexm, input logic [47:0] a);
        rst_dev();
        @(posedge ref_clk) {pw_req, pw_hex} <= {1'b1, hexm};
        @(posedge ref_clk) pw_req <= 1'b0;
        // blank check: 64 cycles, link ignored
        tick(70);
        for (int i = 0; i < 6; i++) send(a[47 - 8 * i -: 8], 1'b0);
    endtask
    task automatic rec(input logic [7:0] ln, ty, input logic [15:0] ad, input logic [7:0] adj,
        input logic [31:0] dat);
        logic [7:0] s, d;
        logic [7:0] q [$];
        s = ln + ad[15:8] + ad[7:0] + ty;
        q = {8'h3a, ln, ad[15:8], ad[7:0], ty};
        for (int i = 0; i < ln; i++) begin
            d = dat[31 - 8 * i -: 8];
            q.push_back(d);
            s += d;
            if (ty == 8'h00) expq.push_back({{ext, 4'h0} + {4'h0, ad} + 20'(i), d});
        end
        if (ty == 8'h02) ext = dat[31:16];
        q.push_back(8'h00 - s + adj);
        foreach (q[k]) send(q[k], ty == 8'h01 && k == q.size() - 1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        logic [159:0] idv;
        logic [7:0] s, d;
        logic [7:0] st [10];
        logic [23:0] pn, pc;
        logic [3:0] n;
        logic err;
        idv = 160'h3a12033d00000002004000021eff0fff000fffff;
        rst_dev();
        @(posedge ref_clk) id_req <= 1'b1;
        @(posedge ref_clk) id_req <= 1'b0;
        tick(30);
        s = 8'h00;
        for (int i = 0; i < 21; i++) begin
            d = (i < 20) ? idv[159 - 8 * i -: 8] : 8'h00 - s;
            if (i > 1) s += d;
            `CHK("id byte", d, rxq[i])
        end
        for (int c = 0; c < 7; c++) begin
            start(1'b1, 48'h004000004001);
            `CHK("blank", 1'b1, blank)
            send(8'h55, 1'b0);
            case (c)
                0: begin
                    rec(8'h02, 8'h02, 16'h0000, 8'h00, 32'h00100000);
                    rec(8'h02, 8'h00, 16'h0123, 8'h00, $random(seed));
                    send(8'h56, 1'b0);
                    rec(8'h00, 8'h01, 16'h0000, 8'h00, 32'h0);
                end
                1: rec(8'h01, 8'h03, 16'h0000, 8'h00, 32'h0);
                2: rec(8'h01, 8'h00, 16'h0000, 8'h01, 32'h0);
                3: rec(8'h01, 8'h02, 16'h0000, 8'h00, 32'h0);
                4: rec(8'h01, 8'h01, 16'h0000, 8'h00, 32'h0);
                5: begin
                    rec(8'h02, 8'h02, 16'h0000, 8'h00, 32'h10000000);
                    rec(8'h01, 8'h00, 16'h0000, 8'h00, 32'h0);
                end
                default: begin
                    @(posedge ref_clk) line_err <= 1'b1;
                    @(posedge ref_clk) line_err <= 1'b0;
                end
            endcase
            tick(40);
            `CHK("fmt err", c != 0, ferr)
            `CHK("halt", {2{c != 0}}, {halt, hh})
            `CHK("pw ok", 1'b1, pok_seen)
            `CHK("replies", (c == 0) ? 2 : 0, rxq.size())
            if (c == 0) begin
                `CHK("end rec", 1'b1, end_seen)
                `CHK("writes", expq.size(), wrq.size())
                foreach (expq[k]) `CHK("write", expq[k], wrq[k])
            end
        end
        start(1'b0, 48'h004000004001);
        tick(20);
        `CHK("erase ok", 1'b1, pok_seen)
        `CHK("erase halt", 1'b0, halt)
        fmem[20'hfffe0] = 8'h00;
        for (int p = 0; p < 7; p++) begin
            pn = (p == 4) ? 24'h003fff : 24'h004000;
            pc = (p == 5) ? 24'h021ef9 : (p == 6) ? 24'h021ef8 : 24'h004001;
            n = (p == 2) ? 4'd7 : 4'd8;
            fmem[pn[19:0]] = {4'h0, n};
            err = pn < 24'h004000 || n < 4'd8 || pc + n > 24'h021f00 || p == 1;
            for (int i = 0; i < n; i++) begin
                st[i] = (p == 3 && i > 2) ? st[2] : 8'($random(seed));
                fmem[20'(pc + i)] = st[i];
                if (i > 1 && st[i] == st[i - 1] && st[i] == st[i - 2]) err = 1'b1;
            end
            start(1'b0, {pn, pc});
            for (int i = 0; i < n; i++) send(st[i] ^ {7'h00, p == 1 && i == 3}, 1'b0);
            tick(40);
            `CHK("pw err", err, perr)
            `CHK("pw ok", !err, pok_seen)
            `CHK("blank", 1'b0, blank)
            `CHK("replies", 0, rxq.size())
        end
        test_done();
    end
endmodule
`default_nettype wire
